/* logic/irq_priority_defs.svh */
// Register offsets, reset values and field positions of the priority bank
`ifndef IRQ_PRIORITY_DEFS_SVH
`define IRQ_PRIORITY_DEFS_SVH

`define ADDR_PRIORITY_1     4'h0
`define ADDR_PRIORITY_2     4'h1
`define ADDR_PRIORITY_3     4'h2
`define ADDR_PRIORITY_4     4'h3
`define ADDR_CAN_PRIORITY   4'h4
`define ADDR_RESET_CAUSE    4'h5
`define ADDR_PERIPH_ENABLE  4'h6
`define ADDR_IRQ_STATUS     4'h7
`define ADDR_IRQ_MASK       4'h8
`define ADDR_CAN_MODE       4'h9

`define NUM_PRIORITY_REGS   5
`define PRIORITY_RESET      8'hFF
`define MASK_PRIORITY_1     8'hFF
`define MASK_PRIORITY_2     8'h8F
`define MASK_PRIORITY_3     8'h3E
`define MASK_PRIORITY_4     8'hF7
`define MASK_CAN_PRIORITY   8'hFF

`define RESET_CAUSE_RESET   8'h7C
`define RESET_CAUSE_WMASK   8'hF3
`define BIT_LEVELS_ENABLE   7
`define BIT_CONFIG_MISMATCH 5

`define STAT_HIGH_REQ       0
`define STAT_LOW_REQ        1
`define STAT_MISMATCH       2
`define STATUS_WIDTH        3

`endif

/* logic/irq_priority_pkg.sv */
// Types shared by the priority bank
package irq_priority_pkg;
    typedef enum logic [1:0] {
        CAN_MODE_LEGACY   = 2'b00,
        CAN_MODE_ENHANCED = 2'b01,
        CAN_MODE_FIFO     = 2'b10,
        CAN_MODE_RSVD     = 2'b11
    } can_mode_type;
endpackage

/* logic/priority_router.sv */
// Routes one source's request to the high or low priority output
`timescale 1ns/1ps
module priority_router (
    input  wire logic pending,
    input  wire logic enabled,
    input  wire logic priority_bit,
    input  wire logic levels_on,
    input  wire logic global_enable,
    output logic      high_req,
    output logic      low_req
);
    logic active;
    assign active   = pending & enabled;
    assign high_req = active & (levels_on ? priority_bit : global_enable);
    assign low_req  = active & levels_on & ~priority_bit;
endmodule

/* logic/peripheral_irq_priority_regs.sv */
// Peripheral interrupt priority register bank with reset-cause register
//
// Behaviour
// - Priority bit one selects high level, zero selects low level.
// - Priority bits act only while the levels-enable bit 7 is set.
// - Levels-enable one gives two levels; zero gives single-level mode.
// - Unimplemented priority bits ignore writes and read as zero.
// - CAN bit 0: buffer 0 in mode 0, absent in mode 1, FIFO in 2.
// - CAN bit 1: buffer 1 in mode 0, programmable buffers in 1 and 2.
// - Mismatch reset clears mismatch flag; software sets it back to one.
// - Reset control register holds cause of last reset or wake-up.
// - One priority bit per source, mirroring flag and enable registers.
// - Levels off: peripheral interrupt needs the global enable bit too.
`timescale 1ns/1ps
`include "irq_priority_defs.svh"
module peripheral_irq_priority_regs
    import irq_priority_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic [39:0] irq_flags,
    input  wire logic [39:0] irq_enables,
    input  wire logic        config_mismatch_event,
    input  wire logic        reset_instruction_event,
    input  wire logic        watchdog_timeout_event,
    input  wire logic        sleep_entry_event,
    input  wire logic        power_on_event,
    input  wire logic        brownout_event,
    output logic             high_irq,
    output logic             low_irq,
    output logic             irq,
    output logic [1:0]       can_mode
);
    localparam logic [7:0] IMPL_MASK [`NUM_PRIORITY_REGS] = '{
        `MASK_PRIORITY_1, `MASK_PRIORITY_2, `MASK_PRIORITY_3,
        `MASK_PRIORITY_4, `MASK_CAN_PRIORITY};

    logic [7:0]  priority_reg [`NUM_PRIORITY_REGS];
    logic [7:0]  reset_cause_control;
    logic        peripheral_irq_global_enable;
    logic [`STATUS_WIDTH-1:0] irq_status;
    logic [`STATUS_WIDTH-1:0] irq_mask;
    can_mode_type             mode;
    logic [39:0] prio_vec;
    logic [39:0] eff_prio;
    logic [39:0] src_high;
    logic [39:0] src_low;
    logic        levels_on;
    logic        any_high;
    logic        any_low;
    logic [7:0]  next_rdata;
    logic [`STATUS_WIDTH-1:0] events;
    logic        mismatch_seen;

    assign levels_on = reset_cause_control[`BIT_LEVELS_ENABLE];
    assign can_mode  = mode;

    // Priority registers, one per group of eight sources
    genvar g;
    generate
        for (g = 0; g < `NUM_PRIORITY_REGS; g++) begin : gen_prio
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    priority_reg[g] <= `PRIORITY_RESET & IMPL_MASK[g];
                end else if (wr && addr == 4'(g)) begin
                    priority_reg[g] <= wdata & IMPL_MASK[g];
                end
            end
            assign prio_vec[g*8 +: 8] = priority_reg[g];
        end
    endgenerate

    // CAN bit 0 is absent in mode 1; bit 1 passes through unchanged in all modes
    always_comb begin
        eff_prio = prio_vec;
        if (mode == CAN_MODE_ENHANCED) begin
            eff_prio[32] = 1'b0;
        end
    end

    // Per-source routing onto the two request levels
    generate
        for (g = 0; g < 40; g++) begin : gen_route
            priority_router u_router (
                .pending       (irq_flags[g]),
                .enabled       (irq_enables[g]),
                .priority_bit  (eff_prio[g]),
                .levels_on     (levels_on),
                .global_enable (peripheral_irq_global_enable),
                .high_req      (src_high[g]),
                .low_req       (src_low[g])
            );
        end
    endgenerate

    assign any_high = |src_high;
    assign any_low  = |src_low;
    assign high_irq = any_high;
    assign low_irq  = any_low;

    // Reset-cause register; hardware events win over software writes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reset_cause_control <= `RESET_CAUSE_RESET;
        end else begin
            if (wr && addr == `ADDR_RESET_CAUSE) begin
                reset_cause_control <=
                    (reset_cause_control & ~`RESET_CAUSE_WMASK) |
                    (wdata & `RESET_CAUSE_WMASK);
            end
            if (config_mismatch_event) begin
                reset_cause_control[`BIT_CONFIG_MISMATCH] <= 1'b0;
            end
            if (reset_instruction_event) begin
                reset_cause_control[4] <= 1'b0;
            end
            if (watchdog_timeout_event) begin
                reset_cause_control[3] <= 1'b0;
            end
            if (sleep_entry_event) begin
                reset_cause_control[2] <= 1'b0;
            end
            if (power_on_event) begin
                reset_cause_control[1] <= 1'b0;
            end
            if (brownout_event) begin
                reset_cause_control[0] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            peripheral_irq_global_enable <= 1'b0;
        end else if (wr && addr == `ADDR_PERIPH_ENABLE) begin
            peripheral_irq_global_enable <= wdata[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode <= CAN_MODE_LEGACY;
        end else if (wr && addr == `ADDR_CAN_MODE) begin
            mode <= can_mode_type'(wdata[1:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_mask <= '0;
        end else if (wr && addr == `ADDR_IRQ_MASK) begin
            irq_mask <= wdata[`STATUS_WIDTH-1:0];
        end
    end

    // Sticky status: read clears, a new event in the same cycle survives
    assign mismatch_seen = config_mismatch_event;
    always_comb begin
        events = '0;
        events[`STAT_HIGH_REQ] = any_high;
        events[`STAT_LOW_REQ]  = any_low;
        events[`STAT_MISMATCH] = mismatch_seen;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_status <= '0;
        end else if (rd && addr == `ADDR_IRQ_STATUS) begin
            irq_status <= events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    always_comb begin
        case (addr)
            `ADDR_PRIORITY_1:    next_rdata = priority_reg[0];
            `ADDR_PRIORITY_2:    next_rdata = priority_reg[1];
            `ADDR_PRIORITY_3:    next_rdata = priority_reg[2];
            `ADDR_PRIORITY_4:    next_rdata = priority_reg[3];
            `ADDR_CAN_PRIORITY:  next_rdata = eff_prio[39:32];
            `ADDR_RESET_CAUSE:   next_rdata = reset_cause_control;
            `ADDR_PERIPH_ENABLE:
                next_rdata = {7'h00, peripheral_irq_global_enable};
            `ADDR_IRQ_STATUS:    next_rdata = {5'h00, irq_status};
            `ADDR_IRQ_MASK:      next_rdata = {5'h00, irq_mask};
            `ADDR_CAN_MODE:      next_rdata = {6'h00, mode};
            default:             next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

/* sim/peripheral_irq_priority_regs_chk.sv */
// Port checker for the priority bank
`timescale 1ns/1ps
`include "irq_priority_defs.svh"
module peripheral_irq_priority_regs_chk
    import irq_priority_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [3:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        config_mismatch_event,
    input wire logic        high_irq,
    input wire logic        low_irq,
    input wire logic        irq,
    input wire logic [1:0]  can_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside read");
    AST_UNMAPPED: assert property (
        rd && addr > 4'h9 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_PRIO2_GAP: assert property (
        rd && addr == `ADDR_PRIORITY_2 |=> rdata[6:4] == 3'h0)
        else $error("priority 2 gap not zero");
    AST_PRIO3_GAP: assert property (
        rd && addr == `ADDR_PRIORITY_3 |=> rdata[7:6] == 2'h0 && !rdata[0])
        else $error("priority 3 gap not zero");
    AST_PRIO4_GAP: assert property (
        rd && addr == `ADDR_PRIORITY_4 |=> !rdata[3])
        else $error("priority 4 gap not zero");
    AST_MODE1_BIT0: assert property (
        rd && addr == `ADDR_CAN_PRIORITY && can_mode == CAN_MODE_ENHANCED
        |=> !rdata[0]) else $error("can bit 0 not zero in mode 1");
    // Write, one idle cycle, then read back of the fully implemented register
    AST_PRIO1_ECHO: assert property (
        (wr && addr == `ADDR_PRIORITY_1) ##1 !wr ##1
        (rd && addr == `ADDR_PRIORITY_1) |=> rdata == $past(wdata, 3))
        else $error("priority 1 write not read back");
    AST_MODE_HOLD: assert property (!(wr && addr == `ADDR_CAN_MODE)
        |=> $stable(can_mode)) else $error("mode changed without write");
    AST_MISMATCH: assert property (config_mismatch_event ##1 (rd &&
        addr == `ADDR_RESET_CAUSE) |=> !rdata[5])
        else $error("mismatch flag not cleared");
    AST_AFTER_RESET: assert property ($rose(rst_b) |-> !high_irq &&
        !low_irq && !irq) else $error("request right after reset");
    COV_HIGH: cover property (high_irq);
    COV_LOW: cover property (low_irq);
    COV_IRQ: cover property (irq);
endmodule

bind peripheral_irq_priority_regs peripheral_irq_priority_regs_chk i_chk (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .config_mismatch_event(config_mismatch_event),
    .high_irq(high_irq), .low_irq(low_irq), .irq(irq), .can_mode(can_mode));

/* sim/test_peripheral_irq_priority_regs.sv */
// Self-checking bench for the priority bank
`timescale 1ns/1ps
`include "irq_priority_defs.svh"
module test_peripheral_irq_priority_regs;
    import irq_priority_pkg::*;
    logic        clk = 0, rst_b = 0, wr = 0, rd = 0;
    logic [3:0]  addr = 0;
    logic [7:0]  wdata = 0, rdata;
    logic [39:0] flags = 0, ens = 0;
    logic [5:0]  ev = 0;
    logic        high_irq, low_irq, irq;
    logic [1:0]  can_mode;
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    logic [7:0]  rv [6] = '{8'hFF, 8'h8F, 8'h3E, 8'hF7, 8'hFF, 8'h7C};

    peripheral_irq_priority_regs i_peripheral_irq_priority_regs (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq_flags(flags), .irq_enables(ens),
        .config_mismatch_event(ev[5]), .reset_instruction_event(ev[4]),
        .watchdog_timeout_event(ev[3]), .sleep_entry_event(ev[2]),
        .power_on_event(ev[1]), .brownout_event(ev[0]),
        .high_irq(high_irq), .low_irq(low_irq), .irq(irq),
        .can_mode(can_mode));

    always #12.5 clk = ~clk;

    task automatic give_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rreg(input logic [3:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask

    task automatic pins(input string n, input logic [2:0] e);
        @(negedge clk);
        chk(n, {5'h00, e}, {5'h00, high_irq, low_irq, irq});
        @(posedge clk);
    endtask

    task automatic t_reset();
        logic [7:0] v;
        for (int i = 0; i < 6; i++) begin
            rreg(i[3:0], v);
            chk("reset value", rv[i], v);
        end
        rreg(4'hF, v);
        chk("unmapped", 8'h00, v);
    endtask

    task automatic t_route();
        flags <= 40'h1;
        ens <= 40'h1;
        wreg(`ADDR_RESET_CAUSE, 8'hFC);
        pins("levels on high", 3'b100);
        wreg(`ADDR_PRIORITY_1, 8'h00);
        pins("levels on low", 3'b010);
        wreg(`ADDR_RESET_CAUSE, 8'h7C);
        pins("levels off", 3'b000);
        wreg(`ADDR_PERIPH_ENABLE, 8'h01);
        pins("single level", 3'b100);
        ens <= 40'h0;
        pins("disabled", 3'b000);
    endtask

    task automatic t_regs();
        logic [7:0] v;
        for (int i = 0; i < 5; i++) begin
            wreg(i[3:0], 8'h00);
            rreg(i[3:0], v);
            chk("cleared", 8'h00, v);
            wreg(i[3:0], 8'hFF);
            rreg(i[3:0], v);
            chk("set", rv[i], v);
        end
    endtask

    task automatic t_can();
        logic [7:0] v;
        for (int m = 0; m < 3; m++) begin
            wreg(`ADDR_CAN_MODE, m[7:0]);
            chk("mode", m[7:0], {6'h00, can_mode});
            rreg(`ADDR_CAN_PRIORITY, v);
            chk("can bits", m == 1 ? 8'hFE : 8'hFF, v);
        end
    endtask

    task automatic t_events();
        logic [7:0] e, v;
        rreg(`ADDR_IRQ_STATUS, v);
        wreg(`ADDR_IRQ_MASK, 8'h04);
        wreg(`ADDR_RESET_CAUSE, 8'h73);
        e = 8'h7F;
        for (int i = 5; i >= 0; i--) begin
            ev <= 6'h01 << i;
            @(posedge clk);
            ev <= 6'h00;
            e[i] = 1'b0;
            rreg(`ADDR_RESET_CAUSE, v);
            chk("cause", e, v);
            wreg(`ADDR_RESET_CAUSE, 8'h73);
            e = e | 8'h73;
        end
        rreg(`ADDR_RESET_CAUSE, v);
        chk("flag restored", e, v);
        pins("irq set", 3'b001);
        rreg(`ADDR_IRQ_STATUS, v);
        chk("status", 8'h04, v);
        pins("irq cleared", 3'b000);
    endtask

    task automatic t_status();
        logic [7:0] v;
        wreg(`ADDR_RESET_CAUSE, 8'hF3);
        wreg(`ADDR_CAN_MODE, 8'h01);
        flags <= 40'h01_0000_0000;
        ens <= 40'h01_0000_0000;
        pins("mode 1 bit 0", 3'b010);
        wreg(`ADDR_CAN_MODE, 8'h02);
        pins("mode 2 bit 0", 3'b100);
        wreg(`ADDR_IRQ_MASK, 8'h03);
        pins("status irq", 3'b101);
        rreg(`ADDR_IRQ_STATUS, v);
        chk("both seen", 8'h03, v);
        ens <= 40'h0;
        rreg(`ADDR_IRQ_STATUS, v);
        chk("set wins", 8'h01, v);
        pins("status cleared", 3'b000);
        wreg(`ADDR_CAN_PRIORITY, 8'h7F);
        flags <= 40'h80_0000_0000;
        ens <= 40'h80_0000_0000;
        pins("source 39 low", 3'b010);
        pins("low seen irq", 3'b011);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_route();
        t_regs();
        t_can();
        t_events();
        t_status();
        give_verdict();
    end
endmodule
